// ---- inc/tbl_pkg.sv ----
// Purpose: Shared constants and types for the tape bootstrap loader
// Assumes: Eight-channel tape characters, 18-bit words
// Notes: Channel 1 is bit 0, channel 8 is bit 7
package tbl_pkg;
	localparam int WORD_W = 18;
	localparam int ADDR_W = 15;
	localparam int CHAR_W = 8;
	localparam int DATA_W = 6;
	localparam int SHIFT_N = 6;
	localparam int OP_HI = 7;
	localparam int OP_LO = 6;
	localparam logic [7:0] CODE_BEGIN = 8'h00_BF;
	localparam logic [1:0] OP_SHIFT = 2'h0;
	localparam logic [1:0] OP_STORE = 2'h1;
	localparam logic [1:0] OP_END = 2'h2;
	localparam logic [1:0] OP_COUNTER = 2'h3;
	localparam logic [5:0] SEL_RESET = 6'h00;
	localparam logic [5:0] AUX_RESET = 6'h3F;
	localparam logic [WORD_W-1:0] WORD_RESET = 18'h0_0000;
	localparam logic [ADDR_W-1:0] PC_RESET = 15'h0000;

	typedef enum logic [1:0] {
		TBL_IDLE = 2'b00,
		TBL_SEEK = 2'b01,
		TBL_LOAD = 2'b10,
		TBL_DONE = 2'b11
	} tbl_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} tbl_mem_wr_s;
endpackage

// ---- design/tbl_loader.sv ----
// Purpose: Hardware bootstrap loader from eight-channel paper tape
// Assumes: Reader presents a character with valid and takes it away on ready
// Notes: Memory writes pass a two-entry buffer; a store character stalls the reader while it is full
// Behaviour
// - The end code with low data bit zero stops loading and starts the program at the counter.
// - Only the begin code uses all eight channels; the end code decodes channels 8, 7 and 1; others decode channels 8 and 7 only.
// - A punched hole is one and a blank is zero, so a sprocket-only character adds zeros.
// - Initiation clears the channel-select register and sets the auxiliary counter to minus one.
// - Initiation starts tape motion so characters are presented.
// - Before the begin code, any other character is discarded without effect.
// - The begin code clears the word register and enters the data phase.
// - Code 00 merges channels 1-6 into the word and shifts it left six.
// - Code 01 merges, stores the word at the counter, increments the counter and clears the word.
// - Code 11 merges, copies the word into the counter and clears the word.
// - No checksum is verified; checksum words are stored as ordinary data.
`timescale 1ns/100ps
`default_nettype none
module tbl_loader
	import tbl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic tape_boot,
	output logic busy,
	output logic run_start,
	output logic [tbl_pkg::ADDR_W-1:0] run_addr,
	output logic [5:0] chan_select,
	output logic [5:0] aux_count,
	// Tape reader
	input wire logic tape_valid,
	input wire logic [tbl_pkg::CHAR_W-1:0] tape_char,
	output logic tape_ready,
	output logic tape_motion,
	// Memory write
	output logic mem_valid,
	input wire logic mem_ready,
	output tbl_pkg::tbl_mem_wr_s mem_wr
);
	import tbl_pkg::*;

	// Reader signals cross from a pin domain
	logic boot_s1_ff, boot_s2_ff, boot_d_ff;
	logic vld_s1_ff, vld_s2_ff, vld_d_ff;
	logic [CHAR_W-1:0] chr_s1_ff, chr_s2_ff;
	tbl_state_e state_ff, nxt_state;
	logic [WORD_W-1:0] word_ff, nxt_word;
	logic [ADDR_W-1:0] pc_ff, nxt_pc;
	logic [5:0] sel_ff, aux_ff;
	logic run_ff;
	logic wait_drop_ff;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			boot_s1_ff <= 1'b0;
			boot_s2_ff <= 1'b0;
			boot_d_ff <= 1'b0;
			vld_s1_ff <= 1'b0;
			vld_s2_ff <= 1'b0;
			vld_d_ff <= 1'b0;
			chr_s1_ff <= '0;
			chr_s2_ff <= '0;
		end else begin
			boot_s1_ff <= tape_boot;
			boot_s2_ff <= boot_s1_ff;
			boot_d_ff <= boot_s2_ff;
			vld_s1_ff <= tape_valid;
			vld_s2_ff <= vld_s1_ff;
			vld_d_ff <= vld_s2_ff;
			chr_s1_ff <= tape_char;
			chr_s2_ff <= chr_s1_ff;
		end
	end

	// Decode
	wire boot_rise = boot_s2_ff & ~boot_d_ff;
	wire [1:0] op = chr_s2_ff[OP_HI:OP_LO];
	wire [WORD_W-1:0] data_ext = {{(WORD_W-DATA_W){1'b0}}, chr_s2_ff[DATA_W-1:0]};
	wire [WORD_W-1:0] merged = word_ff | data_ext;
	// full-width only for begin; end also checks channel 1
	wire is_begin = (chr_s2_ff == CODE_BEGIN);
	wire is_end = (op == OP_END) && !chr_s2_ff[0];
	wire fifo_full;
	// Store needs buffer room; other codes never stall
	wire need_room = (state_ff == TBL_LOAD) && (op == OP_STORE);
	// Synchronised valid lags, so one take waits for valid to drop
	// Valid one stage behind the data bits, so a late-settling bit is never taken
	wire char_avail = vld_s2_ff && vld_d_ff && !wait_drop_ff;
	wire take = char_avail && (state_ff == TBL_SEEK || state_ff == TBL_LOAD)
		&& !(need_room && fifo_full);
	wire do_store = take && (state_ff == TBL_LOAD) && (op == OP_STORE);

	always_comb begin
		nxt_state = state_ff;
		nxt_word = word_ff;
		nxt_pc = pc_ff;
		unique case (state_ff)
			TBL_IDLE, TBL_DONE: begin
				if (boot_rise) begin
					nxt_state = TBL_SEEK;
				end
			end
			TBL_SEEK: begin
				if (take && is_begin) begin
					nxt_word = WORD_RESET;
					nxt_state = TBL_LOAD;
				end
			end
			TBL_LOAD: begin
				if (take) begin
					if (is_end) begin
						nxt_state = TBL_DONE;
					end else begin
						unique case (op)
							OP_SHIFT: begin
								nxt_word = WORD_W'(merged << SHIFT_N);
							end
							OP_STORE: begin
								nxt_word = WORD_RESET;
								nxt_pc = ADDR_W'(pc_ff + 1'b1);
							end
							OP_COUNTER: begin
								nxt_word = WORD_RESET;
								nxt_pc = merged[ADDR_W-1:0];
							end
							// Code 10 with odd low bit is not defined; ignored
							OP_END: begin
								nxt_word = word_ff;
							end
						endcase
					end
				end
			end
		endcase
		if (boot_rise) begin
			nxt_state = TBL_SEEK;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= TBL_IDLE;
			word_ff <= WORD_RESET;
			pc_ff <= PC_RESET;
			sel_ff <= SEL_RESET;
			aux_ff <= AUX_RESET;
			run_ff <= 1'b0;
			wait_drop_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			word_ff <= nxt_word;
			pc_ff <= nxt_pc;
			run_ff <= take && (state_ff == TBL_LOAD) && is_end;
			if (take) begin
				wait_drop_ff <= 1'b1;
			end else if (!vld_s2_ff) begin
				wait_drop_ff <= 1'b0;
			end
			if (boot_rise) begin
				sel_ff <= SEL_RESET;
				aux_ff <= AUX_RESET;
			end
		end
	end

	// Two-entry write buffer
	tbl_mem_wr_s buf_ff [2];
	logic [1:0] cnt_ff;
	logic wr_ptr_ff, rd_ptr_ff;
	assign fifo_full = (cnt_ff == 2'd2);
	wire pop = mem_valid && mem_ready;
	tbl_mem_wr_s push_data;
	assign push_data.addr = pc_ff;
	assign push_data.data = merged;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 2'd0;
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
		end else begin
			cnt_ff <= 2'(cnt_ff + {1'b0, do_store} - {1'b0, pop});
			if (do_store) begin
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (do_store) begin
			buf_ff[wr_ptr_ff] <= push_data;
		end
	end

	// Outputs
	assign mem_valid = (cnt_ff != 2'd0);
	assign mem_wr = buf_ff[rd_ptr_ff];
	assign tape_motion = (state_ff == TBL_SEEK) || (state_ff == TBL_LOAD);
	assign tape_ready = take;
	assign busy = tape_motion;
	assign run_start = run_ff;
	assign run_addr = pc_ff;
	assign chan_select = sel_ff;
	assign aux_count = aux_ff;

	// Assertions
	store_counts_a: assert property (@(posedge ref_clk) disable iff (rst)
		do_store |=> pc_ff == $past(pc_ff) + 1'b1 && word_ff == '0)
		else $error("store did not count and clear");
	shift_merge_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && op == OP_SHIFT |=> word_ff == WORD_W'($past(merged) << 6))
		else $error("shift merge wrong");
	counter_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && op == OP_COUNTER
		|=> pc_ff == $past(merged[ADDR_W-1:0]) && word_ff == '0)
		else $error("counter load wrong");
	end_runs_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && is_end |=> run_start && state_ff == TBL_DONE)
		else $error("end code did not start program");
	seek_discard_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_SEEK && !is_begin && !boot_rise
		|=> state_ff == TBL_SEEK && $stable(word_ff) && $stable(pc_ff))
		else $error("seek character had effect");
	begin_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_SEEK && is_begin && !boot_rise
		|=> state_ff == TBL_LOAD && word_ff == '0)
		else $error("begin code not handled");
	init_values_a: assert property (@(posedge ref_clk) disable iff (rst)
		boot_rise |=> chan_select == 6'h00 && aux_count == 6'h3F && tape_motion)
		else $error("initiation values wrong");
	one_take_a: assert property (@(posedge ref_clk) disable iff (rst)
		take |=> !take)
		else $error("character taken twice");
	store_room_a: assert property (@(posedge ref_clk) disable iff (rst)
		do_store |=> mem_valid)
		else $error("store left buffer empty");
	buf_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
		cnt_ff != 2'd3)
		else $error("write buffer overfilled");
	store_fifo_a: assert property (@(posedge ref_clk) disable iff (rst)
		do_store && !pop |=> cnt_ff == $past(cnt_ff) + 2'd1)
		else $error("store not counted in buffer");
	mem_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		mem_valid && !mem_ready |=> mem_valid && $stable(mem_wr))
		else $error("pending write changed");
	data_or_a: assert property (@(posedge ref_clk) disable iff (rst)
		do_store |-> push_data.data[WORD_W-1:DATA_W] == word_ff[WORD_W-1:DATA_W]
		&& push_data.data[DATA_W-1:0] == (word_ff[DATA_W-1:0] | chr_s2_ff[DATA_W-1:0]))
		else $error("store word not merged");
	group_align_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && op == OP_SHIFT
		|=> word_ff[WORD_W-1:2*DATA_W] == $past(word_ff[2*DATA_W-1:DATA_W]))
		else $error("groups not moved up by six");
	low_group_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && op == OP_SHIFT |=> word_ff[DATA_W-1:0] == '0)
		else $error("low group not cleared by shift");
	run_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		run_start |=> !run_start)
		else $error("start pulse too long");
	run_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
		run_start |-> $past(take && state_ff == TBL_LOAD && is_end))
		else $error("start without end code");
	end_keeps_pc_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && is_end |=> $stable(pc_ff))
		else $error("end code moved the counter");
	done_still_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == TBL_DONE && !boot_rise
		|=> state_ff == TBL_DONE && $stable(pc_ff))
		else $error("loader left done state");
	odd_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		take && state_ff == TBL_LOAD && op == OP_END && chr_s2_ff[0] && !boot_rise
		|=> state_ff == TBL_LOAD && $stable(word_ff) && $stable(pc_ff))
		else $error("undefined code had effect");
	aux_kept_a: assert property (@(posedge ref_clk) disable iff (rst)
		!boot_rise |=> $stable(chan_select) && $stable(aux_count))
		else $error("select or counter moved");
	idle_no_take_a: assert property (@(posedge ref_clk) disable iff (rst)
		!tape_motion |-> !tape_ready)
		else $error("character taken while stopped");
	seek_motion_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == TBL_SEEK || state_ff == TBL_LOAD |-> tape_motion && busy)
		else $error("tape stopped while loading");
	full_stall_a: assert property (@(posedge ref_clk) disable iff (rst)
		fifo_full && need_room |-> !tape_ready)
		else $error("store taken into full buffer");
	ready_valid_a: assert property (@(posedge ref_clk) disable iff (rst)
		tape_ready |-> vld_s2_ff && vld_d_ff && !wait_drop_ff)
		else $error("take without fresh character");
endmodule
`default_nettype wire

// ---- bench/tbl_reader.sv ----
// Purpose: Paper tape reader model
// Assumes: One character per sprocket, held until taken
// Notes: Released data lines show the inverse
`timescale 1ns/100ps
`default_nettype none
module tbl_reader
	import tbl_pkg::*;
(
	// Handshake
	input wire logic ref_clk,
	input wire logic tape_ready,
	output logic tape_valid,
	output logic [tbl_pkg::CHAR_W-1:0] tape_char
);
	initial begin
		tape_valid = 1'b0;
		tape_char = 8'h00;
	end
	task automatic send(input logic [7:0] ch, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge ref_clk);
		tape_valid <= 1'b1;
		tape_char <= ch;
		for (n = 0; n < 200 && !ok; n++) begin
			@(negedge ref_clk);
			ok = (tape_ready === 1'b1);
		end
		@(posedge ref_clk);
		tape_valid <= 1'b0;
		tape_char <= ~ch;
		// Low long enough to be seen through the sync flops
		repeat ($urandom_range(3, 6)) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ---- bench/tbl_loader_tb_top.sv ----
// Purpose: Bench for the tape loader
// Assumes: Reader model, random memory stalls
// Notes: Fixed seed
`timescale 1ns/100ps
`default_nettype none
module tbl_loader_tb_top;
	import tbl_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, tape_boot = 1'b0, mem_ready = 1'b0;
	logic busy, run_start, tape_ready, tape_motion, mem_valid, tape_valid;
	logic [ADDR_W-1:0] run_addr;
	logic [ADDR_W-1:0] pc = 15'h0000;
	logic [5:0] chan_select, aux_count, g0, g1, g2;
	logic [CHAR_W-1:0] tape_char;
	tbl_mem_wr_s mem_wr;
	tbl_mem_wr_s exp_q[$];
	int fail_count = 0, total_checks = 0, i, n;
	int cyc = 0, stall_end = 0;
	bit ok, seen;
	always #10 ref_clk = ~ref_clk;
	tbl_loader dut(.ref_clk(ref_clk), .rst(rst), .tape_boot(tape_boot), .busy(busy),
		.run_start(run_start), .run_addr(run_addr), .chan_select(chan_select),
		.aux_count(aux_count), .tape_valid(tape_valid), .tape_char(tape_char),
		.tape_ready(tape_ready), .tape_motion(tape_motion), .mem_valid(mem_valid),
		.mem_ready(mem_ready), .mem_wr(mem_wr));
	tbl_reader rdr(.ref_clk(ref_clk), .tape_ready(tape_ready), .tape_valid(tape_valid),
		.tape_char(tape_char));
	task automatic check(input logic [47:0] got, input logic [47:0] want);
		total_checks++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR %0t: saw %h want %h", $time, got, want);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic put(input logic [7:0] ch);
		rdr.send(ch, ok);
		if (!ok) begin
			check(48'h0, 48'h1);
			summarize();
		end
	endtask
	function automatic logic [WORD_W-1:0] word_of(input logic [5:0] a, b, c);
		return {a, b, c};
	endfunction
	// Long stall early on so a store meets a full buffer, random stalls after
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		mem_ready <= (cyc >= stall_end) && 1'($urandom_range(0, 1));
	end
	always @(negedge ref_clk) begin
		if (mem_valid === 1'b1 && mem_ready === 1'b1)
			check(mem_wr, exp_q.size() ? exp_q.pop_front() : '1);
		if (run_start === 1'b1) begin
			seen = 1'b1;
			check(run_addr, pc);
		end
	end
	initial begin
		void'($urandom(32'h8aee));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		tape_boot <= 1'b1;
		@(negedge ref_clk);
		check({busy, run_start, mem_valid, aux_count}, {3'b000, AUX_RESET});
		repeat (5) @(negedge ref_clk);
		check({busy, tape_motion, chan_select, aux_count}, {2'b11, SEL_RESET, AUX_RESET});
		// Junk before begin, end code among it
		put(8'h80);
		put(8'h3F);
		for (i = 0; i < 5; i++) put(8'($urandom_range(0, 8'hBE)));
		put(CODE_BEGIN);
		// Sprocket-only word first, counter load in mid-run
		stall_end = cyc + 150;
		for (i = 0; i < 9; i++) begin
			{g0, g1, g2} = (i == 0) ? 18'h0_0000 : 18'($urandom);
			// Expect first: the write can leave before the store char returns
			if (i == 4) pc = ADDR_W'(word_of(g0, g1, g2));
			else begin
				exp_q.push_back('{pc, word_of(g0, g1, g2)});
				pc = pc + 15'h0001;
			end
			// Begin code inside the load phase must do nothing
			if (i == 6) put(CODE_BEGIN);
			put({OP_SHIFT, g0});
			put({OP_SHIFT, g1});
			put({(i == 4) ? OP_COUNTER : OP_STORE, g2});
			if (i == 2) check(cyc >= stall_end, 1'b1);
		end
		put({2'b10, 5'($urandom), 1'b0});
		for (n = 0; n < 50 && (!seen || exp_q.size() != 0); n++) @(negedge ref_clk);
		check(seen, 1'b1);
		check(exp_q.size(), 0);
		summarize();
	end
endmodule
`default_nettype wire
